// >>> rtl/cepc_regs.svh
// cepc constants: field widths, reset values and encodings
`ifndef CEPC_REGS_SVH
`define CEPC_REGS_SVH
`define CEPC_CNT_W 32
`define CEPC_CNT_RST 32'h0000_0000
`define CEPC_EVT_W 4
`define CEPC_NUM_EVT 16
`define CEPC_MODE_DIS 2'h0
`define CEPC_MODE_USER 2'h1
`define CEPC_MODE_SUP 2'h2
`define CEPC_MODE_BOTH 2'h3
`define CEPC_EVT_STALL 4'h0
`define CEPC_EVT_CHIT 4'h1
`define CEPC_EVT_CMISS 4'h2
`define CEPC_EVT_LOOP 4'h3
`define CEPC_EVT_BRANCH 4'h4
`define CEPC_EVT_IRQ 4'h5
`define CEPC_EVT_LOAD 4'h6
`define CEPC_EVT_STORE 4'h7
`define CEPC_EVT_DMA 4'h8
`endif

// >>> rtl/cepc_pkg.sv
// cepc types
`include "cepc_regs.svh"
package cepc_pkg;
  typedef enum logic {cepc_type_exc, cepc_type_emu} cepc_type_t;
  typedef struct packed {
    logic [1:0] mode;
    cepc_type_t kind;
    logic [`CEPC_EVT_W-1:0] sel;
  } cepc_cfg_t;
  typedef struct packed {
    logic load;
    logic [`CEPC_CNT_W-1:0] value;
  } cepc_load_t;
endpackage

// >>> rtl/cepc_unit.sv
// one monitor instance: counter, mode gate and zero detect
`include "cepc_regs.svh"
module cepc_unit #(
  parameter int CNT_W = `CEPC_CNT_W,
  parameter int NUM_EVT = `CEPC_NUM_EVT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // control
  input wire logic enable,
  input wire cepc_pkg::cepc_cfg_t cfg,
  input wire cepc_pkg::cepc_load_t ld,
  // core side
  input wire logic [NUM_EVT-1:0] events,
  input wire logic user_mode,
  // results
  output logic [CNT_W-1:0] count,
  output logic hit_exc,
  output logic hit_emu
);
  import cepc_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cepc_ust_t;
  cepc_ust_t st_r;
  cepc_ust_t st_nxt;
  logic mode_ok;
  logic ev;
  logic wrap;
  // load value is only as wide as the documented counter
  if (CNT_W < 2 || CNT_W > `CEPC_CNT_W || NUM_EVT < 1 ||
      NUM_EVT > (1 << `CEPC_EVT_W)) begin : g_bad_param
    $error("cepc_unit: bad parameters");
  end
  always_comb begin
    case (cfg.mode)
      `CEPC_MODE_USER: mode_ok = user_mode; // [RL4]
      `CEPC_MODE_SUP: mode_ok = !user_mode; // [RL4]
      `CEPC_MODE_BOTH: mode_ok = 1'b1; // [RL4]
      default: mode_ok = 1'b0; // [RL4]
    endcase
    ev = (32'(cfg.sel) < NUM_EVT) ? events[cfg.sel] : 1'b0; // [RL5]
    st_nxt = st_r;
    wrap = 1'b0;
    if (ld.load) begin
      st_nxt.cnt = CNT_W'(ld.value);
    end else if (enable && mode_ok && ev) begin // [RL7]
      st_nxt.cnt = st_r.cnt + 1'b1; // [RL1]
      wrap = (st_nxt.cnt == '0); // [RL2]
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
  // wrap strobes for the next edge; the top registers them
  assign count = st_r.cnt;
  assign hit_exc = wrap && (cfg.kind == cepc_type_exc); // [RL3]
  assign hit_emu = wrap && (cfg.kind == cepc_type_emu); // [RL3]
endmodule

// >>> rtl/cepc_top.sv
// performance monitor top: two instances and reset sync
//
// Operation
// RL1 - 32-bit counter increments on selected event, wraps max to zero
// RL2 - reaching zero raises one notification of the configured kind
// RL3 - exception kind raises exception; emulation kind halts processor
// RL4 - mode selects disabled, user only, supervisor only, or both
// RL5 - event select chooses which core occurrence increments the counter
// RL6 - controller preloads count so wanted occurrence wraps to zero
// RL7 - master enable gates all counting and notification
// RL8 - two independent monitors, each with own mode, type, event, count
`include "cepc_regs.svh"
module cepc_top #(
  parameter int CNT_W = `CEPC_CNT_W,
  parameter int NUM_EVT = `CEPC_NUM_EVT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // debugger control
  input wire logic enable,
  input wire cepc_pkg::cepc_cfg_t cfg0,
  input wire cepc_pkg::cepc_cfg_t cfg1,
  input wire cepc_pkg::cepc_load_t ld0,
  input wire cepc_pkg::cepc_load_t ld1,
  // core event sources and privilege
  input wire logic [NUM_EVT-1:0] events,
  input wire logic user_mode,
  // results
  output logic [CNT_W-1:0] count0,
  output logic [CNT_W-1:0] count1,
  output logic exc_req,
  output logic emu_halt
);
  import cepc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // top state: reset release and combined notifications
  typedef struct packed {
    logic [1:0] sync;
    logic exc;
    logic emu;
  } cepc_top_st_t;
  cepc_top_st_t st_r;
  cepc_top_st_t st_nxt;
  logic rst_int_b;
  logic e0;
  logic e1;
  logic m0;
  logic m1;
  assign rst_int_b = st_r.sync[1];
  ////////////////////////////////////////////////////////////////////////
  // monitor instances
  // the controller presets each count; wrap point chosen by preload [RL6]
  cepc_unit #(.CNT_W(CNT_W), .NUM_EVT(NUM_EVT)) u_mon0 (
    .ref_clk(ref_clk),
    .rst_b(rst_int_b),
    .clk_en(clk_en),
    .enable(enable),
    .cfg(cfg0),
    .ld(ld0),
    .events(events),
    .user_mode(user_mode),
    .count(count0),
    .hit_exc(e0),
    .hit_emu(m0)
  ); // [RL8]
  cepc_unit #(.CNT_W(CNT_W), .NUM_EVT(NUM_EVT)) u_mon1 (
    .ref_clk(ref_clk),
    .rst_b(rst_int_b),
    .clk_en(clk_en),
    .enable(enable),
    .cfg(cfg1),
    .ld(ld1),
    .events(events),
    .user_mode(user_mode),
    .count(count1),
    .hit_exc(e1),
    .hit_emu(m1)
  ); // [RL8]
  ////////////////////////////////////////////////////////////////////////
  // next state; notifications held while clock enable is low
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[0], 1'b1};
    if (!rst_int_b) begin
      st_nxt.exc = 1'b0;
      st_nxt.emu = 1'b0;
    end else if (clk_en) begin
      st_nxt.exc = e0 | e1; // [RL3]
      st_nxt.emu = m0 | m1; // [RL3]
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign exc_req = st_r.exc;
  assign emu_halt = st_r.emu;
endmodule

// >>> tb/cepc_core_model.sv
// core event source model
module cepc_core_model (
  // clock
  input wire logic ref_clk,
  // core event sources and privilege
  output logic [15:0] events = '0,
  output logic user_mode = 1'b0
);
  timeunit 1ns / 1ns;
  // one event line high for n cycles, launched a cycle later
  task automatic fire(int i, int n);
    @(negedge ref_clk);
    events[i] = 1'b1;
    repeat (n) @(negedge ref_clk);
    events = '0;
  endtask
endmodule

// >>> tb/cepc_top_monitor.sv
// rule checks on the monitor top ports
module cepc_top_monitor #(
  parameter int CNT_W = 32,
  parameter int NUM_EVT = 16
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic enable,
  input wire cepc_pkg::cepc_cfg_t cfg0,
  input wire cepc_pkg::cepc_cfg_t cfg1,
  input wire cepc_pkg::cepc_load_t ld0,
  input wire cepc_pkg::cepc_load_t ld1,
  // core side
  input wire logic [NUM_EVT-1:0] events,
  input wire logic user_mode,
  // results
  input wire logic [CNT_W-1:0] count0,
  input wire logic [CNT_W-1:0] count1,
  input wire logic exc_req,
  input wire logic emu_halt
);
  import cepc_pkg::*;
  wire s0 = clk_en & enable & !ld0.load & events[cfg0.sel]
    & (cfg0.mode[0] & user_mode | cfg0.mode[1] & !user_mode);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_load_zero:
  assert property (clk_en & ld0.load |=> count0 == $past(ld0.value)) else $error("load");
  chk_load_one:
  assert property (clk_en & ld1.load |=> count1 == $past(ld1.value)) else $error("load");
  chk_step_zero:
  assert property (s0 |=> count0 == $past(count0) + 1) else $error("step");
  chk_hold_zero:
  assert property (!s0 & !ld0.load |=> $stable(count0)) else $error("hold");
  chk_hold_off:
  assert property (!enable & !ld1.load |=> $stable(count1)) else $error("hold");
  chk_wrap_exc:
  assert property (s0 & &count0 & cfg0.kind == cepc_type_exc |=> exc_req) else $error("wrap");
  chk_note_zero:
  assert property (exc_req | emu_halt |-> count0 == 0 | count1 == 0) else $error("note");
  chk_quiet_off:
  assert property (clk_en & !enable |=> !exc_req & !emu_halt) else $error("quiet");
  cover property (exc_req);
  cover property (emu_halt);
  cover property (ld1.load);
endmodule
bind cepc_top cepc_top_monitor #(.CNT_W(CNT_W), .NUM_EVT(NUM_EVT)) mon (.*);

// >>> tb/testbench.sv
// performance monitor testbench
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module testbench;
  timeunit 1ns / 1ns;
  import cepc_pkg::*;
  logic ref_clk = 0, rst_b = 0, clk_en = 1, enable = 0, user_mode, exc_req, emu_halt;
  logic [15:0] events;
  logic [31:0] count0, count1;
  // unit 0: both modes, exception, loop; unit 1: user, emulation, dma
  cepc_cfg_t cfg0 = 7'h63, cfg1 = 7'h38;
  cepc_load_t ld0 = '0, ld1 = '0;
  int failures = 0, n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  cepc_core_model core (.*);
  cepc_top dut (.*);
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_exc;
    ld0 = {1'b1, 32'hffff_fffe};
    ld1 = {1'b1, 32'hffff_ffff};
    @(negedge ref_clk) {ld0.load, ld1.load} = 2'b00;
    core.fire(4, 1);
    core.fire(3, 2);
    `CHK({count0, exc_req, emu_halt}, 34'h2)
  endtask
  task automatic t_emu;
    core.fire(8, 1);
    enable = 0;
    core.user_mode = 1;
    core.fire(8, 1);
    enable = 1;
    core.fire(8, 1);
    `CHK({count1, count0, emu_halt}, 65'h1)
  endtask
  // unit 0 supervisor only, then disabled; unit 1 sees none of it
  task automatic t_modes;
    cfg0 = 7'h43;
    core.fire(3, 1);
    `CHK(count0, 32'h0)
    core.user_mode = 0;
    core.fire(3, 1);
    `CHK(count0, 32'h1)
    cfg0 = 7'h03;
    core.fire(3, 1);
    `CHK({count0, count1}, 64'h0000_0001_0000_0000)
  endtask
  // clock enable low: neither an event nor a load takes effect
  task automatic t_freeze;
    cfg0 = 7'h63;
    clk_en = 0;
    ld1 = {1'b1, 32'h0000_0005};
    core.fire(3, 1);
    ld1.load = 0;
    clk_en = 1;
    `CHK({count0, count1}, 64'h0000_0001_0000_0000)
    core.fire(3, 1);
    `CHK(count0, 32'h2)
  endtask
  // a load outranks a same-cycle event; a loaded zero does not notify
  task automatic t_load;
    ld0 = {1'b1, 32'h0000_0000};
    core.fire(3, 1);
    ld0.load = 0;
    `CHK({count0, exc_req, emu_halt}, 34'h0)
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_b = 1;
    repeat (3) @(negedge ref_clk);
    enable = 1;
    t_exc;
    t_emu;
    t_modes;
    t_freeze;
    t_load;
    give_verdict;
  end
  initial begin
    #9000 failures++;
    give_verdict;
  end
endmodule
